// File: include/pmic_ctrl_regs.vh
// Register map, field positions, reset values and timing figures of the processor control logic
`ifndef PMIC_CTRL_REGS_VH
`define PMIC_CTRL_REGS_VH

// Serial register port
`define I2C_DEV_ADDR 7'h08

// Register offsets
`define PG_MODE_ADDR 8'he8
`define CTRL_ADDR 8'h20
`define INT_STAT_ADDR 8'h21
`define INT_MASK_ADDR 8'h22
`define STATUS_ADDR 8'h23

// Field positions
`define PG_FAULT_BIT 0
`define CTRL_POWER_ON_REQUEST_EDGE_BIT 0
`define CTRL_STBY_INV_BIT 1
`define CTRL_TRIAL_BIT 2
`define INT_FAULT_BIT 0

// Reset values
`define PG_MODE_RST 8'h00
`define CTRL_RST 3'h0
`define INT_MASK_RST 1'h0

// Clocks and times
`define CLK_HZ 64'd50000000
`define SLOW_HZ 64'd32768
`define RST_DLY_MIN_US 64'd2000
`define RST_DLY_MAX_US 64'd4000
`define FAULT_RST_US 64'd1800
`define FAULT_OFF_US 64'd100000

`endif

// File: hdl/pmic_proc_ctrl.v
// Processor control logic of the power manager: turn-on, standby, reset, warning, interrupt
`include "pmic_ctrl_regs.vh"

module pmic_proc_ctrl (
	// Clock and reset
	input wire clk_i,
	input wire srst_i,
	// Processor interface pins
	input wire power_on_request_i,
	input wire standby_i,
	input wire processor_reset_out_n_i,
	output wire processor_reset_out_n_o,
	output wire processor_reset_out_n_oe_n_o,
	input wire shutdown_warning_n_i,
	output wire shutdown_warning_n_o,
	output wire shutdown_warning_n_oe_n_o,
	input wire fault_interrupt_out_n_i,
	output wire fault_interrupt_out_n_o,
	output wire fault_interrupt_out_n_oe_n_o,
	// Configuration source
	input wire config_source_pin_i,
	input wire fuse_programmed_i,
	input wire fuse_pg_fault_mode_i,
	// Power sequencer and supervisors
	input wire seq_done_i,
	input wire fault_i,
	input wire turn_off_event_i,
	output reg power_up_o,
	output reg standby_mode_o,
	output reg [1:0] startup_source_o,
	// I2C register port
	input wire scl_i,
	input wire sda_i,
	output wire sda_o,
	output wire sda_oe_n_o
);

	localparam [63:0] TICK_W = (`CLK_HZ + `SLOW_HZ / 64'd2) / `SLOW_HZ - 64'd1; // Nearest clock
	localparam [10:0] TICK_DIV = TICK_W[10:0];
	localparam [63:0] RST_DLY_W = (`RST_DLY_MIN_US * `SLOW_HZ + 64'd999999) / 64'd1000000;
	localparam [63:0] FAULT_RST_W = (`FAULT_RST_US * `SLOW_HZ) / 64'd1000000;
	localparam [63:0] FAULT_OFF_W = (`FAULT_OFF_US * `SLOW_HZ) / 64'd1000000;
	localparam [11:0] RST_DLY_TICKS = RST_DLY_W[11:0];
	localparam [11:0] FAULT_RST_TICKS = FAULT_RST_W[11:0];
	localparam [11:0] FAULT_OFF_TICKS = FAULT_OFF_W[11:0];

	localparam [1:0] SRC_FUSE = 2'h0, SRC_BUILTIN = 2'h1, SRC_TRIAL = 2'h2;

	// Power states
	localparam [5:0] ST_OFF = 6'h01, ST_SEQ = 6'h02, ST_RDLY = 6'h04;
	localparam [5:0] ST_ON = 6'h08, ST_WWAIT = 6'h10, ST_WARN = 6'h20;

	// Serial port states
	localparam [5:0] I_IDLE = 6'h01, I_ADDR = 6'h02, I_WR = 6'h04;
	localparam [5:0] I_ACK = 6'h08, I_RD = 6'h10, I_MACK = 6'h20;

	reg [10:0] div_reg;
	reg [5:0] st_reg;
	reg [11:0] dly_reg, fcnt_reg;
	reg tick_reg, fault_seen_reg, rst_assert_reg, warn_reg, power_on_request_prev_reg, fault_prev_reg;
	reg cfg_builtin_reg, int_flag_reg, int_mask_reg;
	reg [7:0] pg_mode_reg;
	reg [2:0] ctrl_reg;

	reg [5:0] i_st_reg;
	reg [3:0] cnt_reg;
	reg [7:0] sh_reg, ptr_reg;
	reg ptr_phase_reg, rw_reg, mack_reg, scl_prev_reg, sda_prev_reg;

	wire fault_mode, trial_en, start_ok, turn_on, fault_rise;
	wire scl_rise, scl_fall, i2c_start, i2c_stop, wr_stb, flag_clr;

	// Register read decode
	function [7:0] read_reg;
		input [7:0] addr;
		begin
			case (addr)
				`PG_MODE_ADDR: read_reg = pg_mode_reg;
				`CTRL_ADDR: read_reg = {5'h00, ctrl_reg};
				`INT_STAT_ADDR: read_reg = {7'h00, int_flag_reg};
				`INT_MASK_ADDR: read_reg = {7'h00, int_mask_reg};
				`STATUS_ADDR: read_reg = {fault_i, standby_mode_o, rst_assert_reg, warn_reg,
					power_up_o, startup_source_o, fault_mode};
				default: read_reg = 8'h00;
			endcase
		end
	endfunction

	assign trial_en = ctrl_reg[`CTRL_TRIAL_BIT];
	assign fault_mode = pg_mode_reg[`PG_FAULT_BIT] | fuse_pg_fault_mode_i;
	assign start_ok = cfg_builtin_reg | trial_en | fuse_programmed_i;
	assign turn_on = ctrl_reg[`CTRL_POWER_ON_REQUEST_EDGE_BIT] ?
		(power_on_request_i & ~power_on_request_prev_reg) : power_on_request_i;
	assign fault_rise = fault_i & ~fault_prev_reg;

	// 32 kHz tick from the system clock
	always @(posedge clk_i) begin
		if (srst_i) begin
			div_reg <= 11'h000;
			tick_reg <= 1'b0;
		end else begin
			tick_reg <= (div_reg == TICK_DIV);
			div_reg <= (div_reg == TICK_DIV) ? 11'h000 : div_reg + 11'h001;
		end
	end

	// Configuration pin caught while reset is held
	always @(posedge clk_i) begin
		if (srst_i) begin
			cfg_builtin_reg <= config_source_pin_i;
		end
	end

	always @* begin
		if (cfg_builtin_reg) begin
			startup_source_o = SRC_BUILTIN;
		end else if (trial_en) begin
			startup_source_o = SRC_TRIAL;
		end else begin
			startup_source_o = SRC_FUSE;
		end
	end

	// Power state machine
	always @(posedge clk_i) begin
		if (srst_i) begin
			st_reg <= ST_OFF;
			dly_reg <= 12'h000;
			fcnt_reg <= 12'h000;
			fault_seen_reg <= 1'b0;
			rst_assert_reg <= 1'b1;
			warn_reg <= 1'b0;
			power_up_o <= 1'b0;
			standby_mode_o <= 1'b0;
			power_on_request_prev_reg <= 1'b0;
			fault_prev_reg <= 1'b0;
		end else begin
			power_on_request_prev_reg <= power_on_request_i;
			fault_prev_reg <= fault_i;
			standby_mode_o <= (st_reg == ST_ON) &
				(standby_i ^ ctrl_reg[`CTRL_STBY_INV_BIT]);
			if (!fault_i || st_reg == ST_OFF) begin
				fcnt_reg <= 12'h000;
			end else if (tick_reg && fcnt_reg != 12'hfff) begin
				fcnt_reg <= fcnt_reg + 12'h001;
			end
			case (st_reg)
				ST_OFF: begin
					rst_assert_reg <= 1'b1;
					warn_reg <= 1'b0;
					power_up_o <= 1'b0;
					if (turn_on && start_ok) begin
						st_reg <= ST_SEQ;
						power_up_o <= 1'b1;
						fault_seen_reg <= 1'b0;
					end
				end
				ST_SEQ: begin
					if (fault_i) begin
						fault_seen_reg <= 1'b1;
					end
					if (seq_done_i) begin
						dly_reg <= 12'h000;
						if (!fault_mode) begin
							st_reg <= ST_RDLY;
						end else begin
							st_reg <= ST_ON;
							rst_assert_reg <= fault_seen_reg | fault_i;
						end
					end
				end
				ST_RDLY: begin
					if (tick_reg) begin
						dly_reg <= dly_reg + 12'h001;
					end
					if (dly_reg == RST_DLY_TICKS + 12'h001) begin // Spare tick covers divider phase
						rst_assert_reg <= 1'b0;
						st_reg <= ST_ON;
					end
				end
				ST_ON: begin
				end
				ST_WWAIT: begin
					if (tick_reg) begin
						warn_reg <= 1'b1;
						st_reg <= ST_WARN;
					end
				end
				ST_WARN: begin
					if (tick_reg) begin
						warn_reg <= 1'b0;
						power_up_o <= 1'b0;
						st_reg <= ST_OFF;
					end
				end
				default: begin
					st_reg <= ST_OFF;
				end
			endcase
			if (st_reg == ST_SEQ || st_reg == ST_RDLY || st_reg == ST_ON) begin
				if (turn_off_event_i) begin
					rst_assert_reg <= 1'b1;
					st_reg <= ST_WWAIT;
				end else if (fault_mode && fcnt_reg >= FAULT_OFF_TICKS) begin
					rst_assert_reg <= 1'b1;
					st_reg <= ST_WWAIT;
				end else if (fault_mode && fcnt_reg >= FAULT_RST_TICKS) begin
					rst_assert_reg <= 1'b1;
				end
			end
		end
	end

	// Open-drain pins: enable low pulls the line low
	assign processor_reset_out_n_o = 1'b0;
	assign processor_reset_out_n_oe_n_o = ~rst_assert_reg;
	assign shutdown_warning_n_o = 1'b0;
	assign shutdown_warning_n_oe_n_o = ~warn_reg;
	assign fault_interrupt_out_n_o = 1'b0;
	assign fault_interrupt_out_n_oe_n_o = ~(int_flag_reg & ~int_mask_reg);

	// Serial register port
	assign scl_rise = scl_i & ~scl_prev_reg;
	assign scl_fall = ~scl_i & scl_prev_reg;
	assign i2c_start = scl_i & scl_prev_reg & sda_prev_reg & ~sda_i;
	assign i2c_stop = scl_i & scl_prev_reg & ~sda_prev_reg & sda_i;
	assign wr_stb = scl_fall & (i_st_reg == I_WR) & (cnt_reg == 4'h8) & ~ptr_phase_reg;
	assign flag_clr = wr_stb & (ptr_reg == `INT_STAT_ADDR) & sh_reg[`INT_FAULT_BIT];
	assign sda_o = 1'b0;
	assign sda_oe_n_o = ~((i_st_reg == I_ACK) | ((i_st_reg == I_RD) & ~sh_reg[7]));

	always @(posedge clk_i) begin
		if (srst_i) begin
			i_st_reg <= I_IDLE;
			cnt_reg <= 4'h0;
			sh_reg <= 8'h00;
			ptr_reg <= 8'h00;
			ptr_phase_reg <= 1'b0;
			rw_reg <= 1'b0;
			mack_reg <= 1'b0;
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
		end else begin
			scl_prev_reg <= scl_i;
			sda_prev_reg <= sda_i;
			if (i2c_start) begin
				i_st_reg <= I_ADDR;
				cnt_reg <= 4'h0;
			end else if (i2c_stop) begin
				i_st_reg <= I_IDLE;
			end else if (scl_rise) begin
				if (i_st_reg == I_ADDR || i_st_reg == I_WR) begin
					sh_reg <= {sh_reg[6:0], sda_i};
					cnt_reg <= cnt_reg + 4'h1;
				end else if (i_st_reg == I_RD) begin
					cnt_reg <= cnt_reg + 4'h1;
				end else if (i_st_reg == I_MACK) begin
					mack_reg <= ~sda_i;
				end
			end else if (scl_fall) begin
				case (i_st_reg)
					I_ADDR: begin
						if (cnt_reg == 4'h8) begin
							if (sh_reg[7:1] == `I2C_DEV_ADDR) begin
								rw_reg <= sh_reg[0];
								ptr_phase_reg <= ~sh_reg[0];
								i_st_reg <= I_ACK;
							end else begin
								i_st_reg <= I_IDLE;
							end
						end
					end
					I_WR: begin
						if (cnt_reg == 4'h8) begin
							if (ptr_phase_reg) begin
								ptr_reg <= sh_reg;
								ptr_phase_reg <= 1'b0;
							end else begin
								ptr_reg <= ptr_reg + 8'h01;
							end
							i_st_reg <= I_ACK;
						end
					end
					I_ACK: begin
						cnt_reg <= 4'h0;
						if (rw_reg) begin
							sh_reg <= read_reg(ptr_reg);
							ptr_reg <= ptr_reg + 8'h01;
							i_st_reg <= I_RD;
						end else begin
							i_st_reg <= I_WR;
						end
					end
					I_RD: begin
						if (cnt_reg == 4'h8) begin
							i_st_reg <= I_MACK;
						end else begin
							sh_reg <= {sh_reg[6:0], 1'b1};
						end
					end
					I_MACK: begin
						if (mack_reg) begin
							cnt_reg <= 4'h0;
							sh_reg <= read_reg(ptr_reg);
							ptr_reg <= ptr_reg + 8'h01;
							i_st_reg <= I_RD;
						end else begin
							i_st_reg <= I_IDLE;
						end
					end
					default: begin
						i_st_reg <= I_IDLE;
					end
				endcase
			end
		end
	end

	// Register file
	always @(posedge clk_i) begin
		if (srst_i) begin
			pg_mode_reg <= `PG_MODE_RST;
			ctrl_reg <= `CTRL_RST;
			int_mask_reg <= `INT_MASK_RST;
			int_flag_reg <= 1'b0;
		end else begin
			if (wr_stb && ptr_reg == `PG_MODE_ADDR) begin
				pg_mode_reg <= sh_reg;
			end
			if (wr_stb && ptr_reg == `CTRL_ADDR) begin
				ctrl_reg <= sh_reg[2:0];
			end
			if (wr_stb && ptr_reg == `INT_MASK_ADDR) begin
				int_mask_reg <= sh_reg[`INT_FAULT_BIT];
			end
			if (fault_rise) begin
				int_flag_reg <= 1'b1;
			end else if (flag_clr) begin
				int_flag_reg <= 1'b0;
			end
		end
	end

endmodule // pmic_proc_ctrl

// File: tb/proc_model.sv
// Processor side model: pull-ups on the open-drain lines and the serial data wire
module proc_model (
	// Device pin drives and enables, and the master's drive of the data wire
	input wire processor_reset_out_n_o,
	input wire processor_reset_out_n_oe_n_o,
	input wire shutdown_warning_n_o,
	input wire shutdown_warning_n_oe_n_o,
	input wire fault_interrupt_out_n_o,
	input wire fault_interrupt_out_n_oe_n_o,
	input wire sda_o,
	input wire sda_oe_n_o,
	input wire sda_m,
	// Resolved pin levels
	output wire processor_reset_out_n_i,
	output wire shutdown_warning_n_i,
	output wire fault_interrupt_out_n_i,
	output wire sda_i
);
	timeunit 1ns;
	timeprecision 100ps;
	// Released line floats to its pull-up level
	assign processor_reset_out_n_i = processor_reset_out_n_oe_n_o | processor_reset_out_n_o;
	assign shutdown_warning_n_i = shutdown_warning_n_oe_n_o | shutdown_warning_n_o;
	assign fault_interrupt_out_n_i = fault_interrupt_out_n_oe_n_o | fault_interrupt_out_n_o;
	assign sda_i = sda_m & (sda_oe_n_o | sda_o);
endmodule // proc_model

// File: tb/pmic_proc_ctrl_chk.sv
// Assertion checker for the processor control logic
module pmic_proc_ctrl_chk (
	// Clock and reset
	input wire clk_i,
	input wire srst_i,
	// Observed pins
	input wire power_up_o,
	input wire standby_mode_o,
	input wire fault_i,
	input wire turn_off_event_i,
	input wire seq_done_i,
	input wire fuse_pg_fault_mode_i,
	input wire processor_reset_out_n_oe_n_o,
	input wire shutdown_warning_n_oe_n_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [12:0] warn_cnt;
	logic [22:0] flt_cnt;
	logic seq_seen;
	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i);
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			warn_cnt <= 13'h0;
			flt_cnt <= 23'h0;
			seq_seen <= 1'b0;
		end else begin
			warn_cnt <= shutdown_warning_n_oe_n_o ? 13'h0 : warn_cnt + 13'h1;
			flt_cnt <= (fault_i && power_up_o) ? flt_cnt + {22'h0, ~&flt_cnt} : 23'h0;
			seq_seen <= power_up_o && (seq_seen || seq_done_i);
		end
	end
	sequence s_pulse_end;
		!shutdown_warning_n_oe_n_o ##1 shutdown_warning_n_oe_n_o;
	endsequence
	sequence s_turn_off;
		turn_off_event_i && power_up_o;
	endsequence
	a_warn_then_off: assert property (s_pulse_end |-> !power_up_o)
		else $error("power stays up after warning");
	a_warn_pulse_len: assert property ($rose(shutdown_warning_n_oe_n_o) |-> warn_cnt == 13'd1526)
		else $error("warning pulse length wrong");
	a_off_holds_reset: assert property (!power_up_o |-> !processor_reset_out_n_oe_n_o)
		else $error("reset released while off");
	a_turnoff_asserts: assert property (s_turn_off |=> !processor_reset_out_n_oe_n_o)
		else $error("turn-off did not assert reset");
	a_release_after_seq: assert property ($rose(processor_reset_out_n_oe_n_o) |-> seq_seen)
		else $error("reset released before sequence end");
	a_fault_reset: assert property (fuse_pg_fault_mode_i && flt_cnt == 23'd90100
		|-> !processor_reset_out_n_oe_n_o)
		else $error("persisting fault left reset released");
	a_fault_off: assert property (fuse_pg_fault_mode_i |-> flt_cnt != 23'd5004000)
		else $error("persisting fault did not power off");
	a_standby_when_on: assert property (standby_mode_o |-> power_up_o)
		else $error("standby while off");
endmodule // pmic_proc_ctrl_chk
bind pmic_proc_ctrl pmic_proc_ctrl_chk chk (
	.clk_i(clk_i),
	.srst_i(srst_i),
	.power_up_o(power_up_o),
	.standby_mode_o(standby_mode_o),
	.fault_i(fault_i),
	.turn_off_event_i(turn_off_event_i),
	.seq_done_i(seq_done_i),
	.fuse_pg_fault_mode_i(fuse_pg_fault_mode_i),
	.processor_reset_out_n_oe_n_o(processor_reset_out_n_oe_n_o),
	.shutdown_warning_n_oe_n_o(shutdown_warning_n_oe_n_o)
);

// File: tb/pmic_proc_ctrl_tb.sv
// Self-checking bench of the processor control logic
`include "pmic_ctrl_regs.vh"
module pmic_proc_ctrl_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_i = 1'b0, srst_i = 1'b1, power_on_request_i = 1'b0, standby_i = 1'b0;
	logic config_source_pin_i = 1'b1, fuse_programmed_i = 1'b0, fuse_pg_fault_mode_i = 1'b0;
	logic seq_done_i = 1'b0, fault_i = 1'b0, turn_off_event_i = 1'b0, scl_i = 1'b1, sda_m = 1'b1;
	wire processor_reset_out_n_i, shutdown_warning_n_i, fault_interrupt_out_n_i, sda_i;
	wire processor_reset_out_n_o, processor_reset_out_n_oe_n_o, shutdown_warning_n_o;
	wire shutdown_warning_n_oe_n_o, fault_interrupt_out_n_o, fault_interrupt_out_n_oe_n_o;
	wire power_up_o, standby_mode_o, sda_o, sda_oe_n_o;
	wire [1:0] startup_source_o;
	int bad_count = 0, comparisons = 0;
	pmic_proc_ctrl dut (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.power_on_request_i(power_on_request_i),
		.standby_i(standby_i),
		.processor_reset_out_n_i(processor_reset_out_n_i),
		.processor_reset_out_n_o(processor_reset_out_n_o),
		.processor_reset_out_n_oe_n_o(processor_reset_out_n_oe_n_o),
		.shutdown_warning_n_i(shutdown_warning_n_i),
		.shutdown_warning_n_o(shutdown_warning_n_o),
		.shutdown_warning_n_oe_n_o(shutdown_warning_n_oe_n_o),
		.fault_interrupt_out_n_i(fault_interrupt_out_n_i),
		.fault_interrupt_out_n_o(fault_interrupt_out_n_o),
		.fault_interrupt_out_n_oe_n_o(fault_interrupt_out_n_oe_n_o),
		.config_source_pin_i(config_source_pin_i),
		.fuse_programmed_i(fuse_programmed_i),
		.fuse_pg_fault_mode_i(fuse_pg_fault_mode_i),
		.seq_done_i(seq_done_i),
		.fault_i(fault_i),
		.turn_off_event_i(turn_off_event_i),
		.power_up_o(power_up_o),
		.standby_mode_o(standby_mode_o),
		.startup_source_o(startup_source_o),
		.scl_i(scl_i),
		.sda_i(sda_i),
		.sda_o(sda_o),
		.sda_oe_n_o(sda_oe_n_o)
	);
	proc_model model (
		.processor_reset_out_n_o(processor_reset_out_n_o),
		.processor_reset_out_n_oe_n_o(processor_reset_out_n_oe_n_o),
		.shutdown_warning_n_o(shutdown_warning_n_o),
		.shutdown_warning_n_oe_n_o(shutdown_warning_n_oe_n_o),
		.fault_interrupt_out_n_o(fault_interrupt_out_n_o),
		.fault_interrupt_out_n_oe_n_o(fault_interrupt_out_n_oe_n_o),
		.sda_o(sda_o),
		.sda_oe_n_o(sda_oe_n_o),
		.sda_m(sda_m),
		.processor_reset_out_n_i(processor_reset_out_n_i),
		.shutdown_warning_n_i(shutdown_warning_n_i),
		.fault_interrupt_out_n_i(fault_interrupt_out_n_i),
		.sda_i(sda_i)
	);
	initial forever #10 clk_i = ~clk_i;
	task step(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task chk(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			bad_count++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task give_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task limit_hit(input int n, input int lim);
		if (n >= lim) begin
			bad_count++;
			$display("Error at %0t: wait limit %h reached %h", $time, lim, n);
			give_verdict;
		end
	endtask
	task i2c_bit(input logic b);
		sda_m = b;
		step(4);
		scl_i = 1'b1;
		step(4);
		scl_i = 1'b0;
	endtask
	task i2c_byte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--)
			i2c_bit(b[i]);
		sda_m = 1'b1;
		step(6);
		scl_i = 1'b1;
		chk(sda_i, 1'b0);
		step(4);
		scl_i = 1'b0;
	endtask
	task reg_wr(input logic [7:0] a, input logic [7:0] d);
		step(4);
		sda_m = 1'b0;
		step(4);
		scl_i = 1'b0;
		i2c_byte({`I2C_DEV_ADDR, 1'b0});
		i2c_byte(a);
		i2c_byte(d);
		sda_m = 1'b0;
		step(4);
		scl_i = 1'b1;
		step(4);
		sda_m = 1'b1;
		step(4);
	endtask
	task reg_rd(input logic [7:0] a, output logic [7:0] d);
		step(4);
		sda_m = 1'b0;
		step(4);
		scl_i = 1'b0;
		i2c_byte({`I2C_DEV_ADDR, 1'b0});
		i2c_byte(a);
		step(4);
		scl_i = 1'b1;
		step(4);
		sda_m = 1'b0;
		step(4);
		scl_i = 1'b0;
		i2c_byte({`I2C_DEV_ADDR, 1'b1});
		for (int i = 7; i >= 0; i--) begin
			step(4);
			scl_i = 1'b1;
			step(4);
			d[i] = sda_i;
			scl_i = 1'b0;
		end
		i2c_bit(1'b1);
		sda_m = 1'b0;
		step(4);
		scl_i = 1'b1;
		step(4);
		sda_m = 1'b1;
		step(4);
	endtask
	task power_up_seq(output int cyc);
		power_on_request_i = 1'b1;
		step(2);
		chk(power_up_o, 1'b1);
		power_on_request_i = 1'b0;
		seq_done_i = 1'b1;
		cyc = 0;
		while (processor_reset_out_n_i !== 1'b1 && cyc < 220000) begin
			step(1);
			cyc++;
		end
		limit_hit(cyc, 220000);
		seq_done_i = 1'b0;
	endtask
	task power_down;
		int n;
		turn_off_event_i = 1'b1;
		step(1);
		turn_off_event_i = 1'b0;
		step(1);
		chk(processor_reset_out_n_i, 1'b0);
		n = 0;
		while (shutdown_warning_n_i && n < 3200) begin
			step(1);
			n++;
		end
		limit_hit(n, 3200);
		n = 0;
		while (!shutdown_warning_n_i && n < 3200) begin
			step(1);
			n++;
		end
		limit_hit(n, 3200);
		chk(n, 1526);
		chk(power_up_o, 1'b0);
		chk(processor_reset_out_n_i, 1'b0);
		step(4);
		chk(shutdown_warning_n_i, 1'b1);
	endtask
	task fault_pulse;
		fault_i = 1'b1;
		step(20);
		fault_i = 1'b0;
		step(2);
	endtask
	task t_fault_fuse;
		int c;
		logic [7:0] d;
		fuse_pg_fault_mode_i = 1'b1;
		power_up_seq(c);
		chk(c <= 3, 1'b1);
		standby_i = 1'b1;
		step(2);
		chk(standby_mode_o, 1'b1);
		reg_wr(`CTRL_ADDR, 8'h02);
		chk(standby_mode_o, 1'b0);
		standby_i = 1'b0;
		step(2);
		chk(standby_mode_o, 1'b1);
		reg_wr(`CTRL_ADDR, 8'h00);
		fault_pulse;
		chk(fault_interrupt_out_n_i, 1'b0);
		chk(processor_reset_out_n_i, 1'b1);
		reg_rd(`INT_STAT_ADDR, d);
		chk(d, 8'h01);
		reg_wr(`INT_STAT_ADDR, 8'h01);
		chk(fault_interrupt_out_n_i, 1'b1);
		reg_rd(`INT_STAT_ADDR, d);
		chk(d, 8'h00);
		reg_wr(`INT_MASK_ADDR, 8'h01);
		fault_pulse;
		chk(fault_interrupt_out_n_i, 1'b1);
		power_down;
		fuse_pg_fault_mode_i = 1'b0;
		$display("done fault mode by fuse");
	endtask
	task t_default;
		int c;
		logic [7:0] d;
		reg_wr(`PG_MODE_ADDR, 8'h01);
		reg_rd(`PG_MODE_ADDR, d);
		chk(d, 8'h01);
		power_up_seq(c);
		chk(c <= 3, 1'b1);
		power_down;
		srst_i = 1'b1;
		step(2);
		srst_i = 1'b0;
		power_up_seq(c);
		chk(c >= 100000 && c <= 200000, 1'b1);
		fault_pulse;
		chk(processor_reset_out_n_i, 1'b1);
		power_down;
		$display("done register and default modes");
	endtask
	task t_source;
		chk(startup_source_o, 2'h1);
		srst_i = 1'b1;
		config_source_pin_i = 1'b0;
		step(2);
		srst_i = 1'b0;
		power_on_request_i = 1'b1;
		step(4);
		chk(power_up_o, 1'b0);
		chk(startup_source_o, 2'h0);
		power_on_request_i = 1'b0;
		reg_wr(`CTRL_ADDR, 8'h05);
		power_on_request_i = 1'b1;
		step(2);
		chk(power_up_o, 1'b1);
		chk(startup_source_o, 2'h2);
		power_down;
		chk(power_up_o, 1'b0);
		power_on_request_i = 1'b0;
		$display("done configuration source");
	endtask
	initial begin
		step(2);
		srst_i = 1'b0;
		step(1);
		chk(processor_reset_out_n_i, 1'b0);
		t_fault_fuse;
		t_default;
		t_source;
		give_verdict;
	end
endmodule // pmic_proc_ctrl_tb
